/* File: hdl/sld_consts.svh */
// register map, field positions, reset values and timing counts
`ifndef SLD_CONSTS_SVH
`define SLD_CONSTS_SVH

// register byte offsets
`define SLD_CTRL_OFS 12'h000
`define SLD_SEL_OFS 12'h004
`define SLD_STAT_OFS 12'h008
`define SLD_MASK_OFS 12'h00c

// control register fields
`define SLD_CTRL_EN_BIT 7
`define SLD_CTRL_OUT_BIT 5
`define SLD_CTRL_RDY_BIT 4
`define SLD_CTRL_RISE_BIT 1
`define SLD_CTRL_FALL_BIT 0

// trip level select
`define SLD_LEVELS 16
`define SLD_SEL_W 4
`define SLD_SEL_RST 4'h0

// status and mask fields
`define SLD_STAT_FLAG_BIT 0
`define SLD_MASK_IE_BIT 0
`define SLD_MASK_GIE_BIT 1

// timing
`define SLD_CLK_PERIOD_NS 40
`define SLD_SETTLE_NS 25000
`define SLD_SETTLE_CYC \
  ((`SLD_SETTLE_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)

`endif

/* File: hdl/sld_pkg.sv */
// types shared by the supply level detector files
package sld_pkg;

  // software controlled detector settings
  typedef struct packed {
    logic en;
    logic rise;
    logic fall;
  } sld_ctrl_t;

  // accepted bus address phase, held into the data phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] idx;
  } sld_req_t;

  // detector power-up sequence
  typedef enum logic [1:0] {
    SLD_OFF = 2'b00,
    SLD_SETTLE = 2'b01,
    SLD_READY = 2'b10
  } sld_state_t;

endpackage

/* File: hdl/sld_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module sld_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] val_q;
  logic [W-1:0] val_d;

  // a bit only moves once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign val_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : val_q[g];
    end
  endgenerate

  // meta_q feeds s2_q and nothing else
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      val_q <= '0;
    end else begin
      meta_q <= async_in;
      s2_q <= meta_q;
      s3_q <= s2_q;
      val_q <= val_d;
    end
  end

  assign sync_out = val_q;
endmodule // sld_sync
`default_nettype wire

/* File: hdl/sld_top.sv */
// supply level detector control with AHB-Lite register slave
`include "sld_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module sld_top
  import sld_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `SLD_SETTLE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic por_rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic cmp_raw_in,
  input wire logic ref_ok_raw_in,
  output logic [`SLD_SEL_W-1:0] level_sel_out,
  output logic detector_power_out,
  output logic irq_out,
  output logic wake_out
);
  localparam int CW = $clog2(SETTLE_CYC + 1);

  // decode an address into a register index; hit only inside the map
  function automatic logic [2:0] sld_decode(input logic [31:0] a);
    logic hit;
    hit = (a[31:4] == 28'h0000000);
    return {hit, a[3:2]};
  endfunction

  sld_ctrl_t ctrl_q, ctrl_d;
  sld_req_t req_q, req_d;
  sld_state_t state_q, state_d;
  logic [`SLD_SEL_W-1:0] sel_q, sel_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [31:0] rdata_q, rdata_d;
  logic flag_q, flag_d;
  logic ie_q, ie_d;
  logic gie_q, gie_d;
  logic prev_q, prev_d;
  logic cmp_s;
  logic ref_ok_s;
  logic ready;
  logic out_now;
  logic evt;
  logic addr_ok;
  logic [2:0] dec;
  logic wr_ctrl, wr_sel, wr_stat, wr_mask;
  logic [31:0] ctrl_word;

  // comparator and reference status come from the analog side
  sld_sync #(.W(2)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .async_in({ref_ok_raw_in, cmp_raw_in}),
    .sync_out({ref_ok_s, cmp_s})
  );

  assign ready = (state_q == SLD_READY);
  // status only means something while powered; reads 1 at or below level
  assign out_now = ctrl_q.en & cmp_s;
  assign dec = sld_decode(haddr_in);
  assign addr_ok = hsel_in & hready_in & htrans_in[1];

  // data phase write strobes
  assign wr_ctrl = req_q.valid & req_q.write & (req_q.idx == 2'd0);
  assign wr_sel = req_q.valid & req_q.write & (req_q.idx == 2'd1);
  assign wr_stat = req_q.valid & req_q.write & (req_q.idx == 2'd2);
  assign wr_mask = req_q.valid & req_q.write & (req_q.idx == 2'd3);

  // control register image as software reads it
  always_comb begin
    ctrl_word = 32'h00000000;
    ctrl_word[`SLD_CTRL_EN_BIT] = ctrl_q.en;
    ctrl_word[`SLD_CTRL_OUT_BIT] = out_now;
    ctrl_word[`SLD_CTRL_RDY_BIT] = ready;
    ctrl_word[`SLD_CTRL_RISE_BIT] = ctrl_q.rise;
    ctrl_word[`SLD_CTRL_FALL_BIT] = ctrl_q.fall;
  end

  // bus slave: zero wait states, always OKAY, reads sampled in address phase
  always_comb begin
    req_d = '0;
    rdata_d = 32'h00000000;
    if (addr_ok) begin
      req_d.valid = dec[2];
      req_d.write = hwrite_in;
      req_d.idx = dec[1:0];
      if (!hwrite_in && dec[2]) begin
        case (dec[1:0])
          2'd0: rdata_d = ctrl_word;
          2'd1: rdata_d = {28'h0000000, sel_q};
          2'd2: rdata_d = {31'h00000000, flag_q};
          2'd3: rdata_d = {30'h00000000, gie_q, ie_q};
          default: rdata_d = 32'h00000000;
        endcase
      end
    end
  end

  // software writable settings; a data phase write lands at its end
  always_comb begin
    ctrl_d = ctrl_q;
    sel_d = sel_q;
    ie_d = ie_q;
    gie_d = gie_q;
    if (wr_ctrl) begin
      ctrl_d.en = hwdata_in[`SLD_CTRL_EN_BIT];
      ctrl_d.rise = hwdata_in[`SLD_CTRL_RISE_BIT];
      ctrl_d.fall = hwdata_in[`SLD_CTRL_FALL_BIT];
    end
    if (wr_sel) begin
      sel_d = hwdata_in[`SLD_SEL_W-1:0];
    end
    if (wr_mask) begin
      ie_d = hwdata_in[`SLD_MASK_IE_BIT];
      gie_d = hwdata_in[`SLD_MASK_GIE_BIT];
    end
  end

  // power-up sequence: the reference needs its settle time after each enable
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      SLD_OFF: begin
        if (ctrl_q.en) begin
          state_d = SLD_SETTLE;
          cnt_d = CW'(SETTLE_CYC);
        end
      end
      SLD_SETTLE: begin
        if (!ctrl_q.en) begin
          state_d = SLD_OFF;
        end else if (cnt_q != '0) begin
          cnt_d = cnt_q - CW'(1);
        end else if (ref_ok_s) begin
          state_d = SLD_READY;
        end
      end
      SLD_READY: begin
        if (!ctrl_q.en) begin
          state_d = SLD_OFF;
        end
      end
      default: state_d = SLD_OFF;
    endcase
  end

  // crossings only count while ready, so power switching cannot make one
  always_comb begin
    prev_d = cmp_s;
    evt = ready & ctrl_q.en &
      ((ctrl_q.fall & cmp_s & ~prev_q) |
       (ctrl_q.rise & ~cmp_s & prev_q));
    // a new event beats a write-one clear in the same cycle
    flag_d = evt | (flag_q & ~(wr_stat & hwdata_in[`SLD_STAT_FLAG_BIT]));
  end

  // control state; any device reset turns the detector off
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= '0;
      req_q <= '0;
      state_q <= SLD_OFF;
      cnt_q <= '0;
      rdata_q <= 32'h00000000;
      flag_q <= 1'b0;
      ie_q <= 1'b0;
      gie_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      req_q <= req_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
      flag_q <= flag_d;
      ie_q <= ie_d;
      gie_q <= gie_d;
      prev_q <= prev_d;
    end
  end

  // trip level survives ordinary resets, cleared by power-on only
  always_ff @(posedge sys_clk_in or negedge por_rstn_in) begin
    if (!por_rstn_in) begin
      sel_q <= `SLD_SEL_RST;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign hrdata_out = rdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign level_sel_out = sel_q;
  assign detector_power_out = ctrl_q.en;
  // no request until ready, even with both enables set
  assign irq_out = flag_q & ie_q & gie_q & ready;
  // wake does not need the global enable: sleep exit is separate
  assign wake_out = flag_q & ie_q & ctrl_q.en;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_fall_cross;
    // a disable landing on the crossing edge legally swallows it
    ready && ctrl_q.en && ctrl_q.fall && !cmp_s ##1
      cmp_s && ready && ctrl_q.en && ctrl_q.fall;
  endsequence

  sequence s_rise_cross;
    ready && ctrl_q.en && ctrl_q.rise && cmp_s ##1
      !cmp_s && ready && ctrl_q.en && ctrl_q.rise;
  endsequence

  sequence s_rd_ctrl;
    addr_ok && !hwrite_in && dec == 3'b100;
  endsequence

  chk_irq_needs_ready:
    assert property (irq_out |-> ready && state_q == SLD_READY)
    else $error("interrupt raised before ready");

  chk_flag_after_settle:
    assert property ($rose(flag_q) |-> $past(state_q) == SLD_READY)
    else $error("event flag set before settle time expired");

  chk_no_flag_on_toggle:
    assert property ($rose(flag_q) |-> $past(evt))
    else $error("event flag set without a crossing");

  chk_fall_sets_flag:
    assert property (s_fall_cross |=> flag_q)
    else $error("fall crossing did not set the flag");

  chk_rise_sets_flag:
    assert property (s_rise_cross |=> flag_q)
    else $error("rise crossing did not set the flag");

  chk_rdy_low_after_en:
    assert property ($rose(ctrl_q.en) |=> !ready [*2])
    else $error("ready rose too soon after enable");

  chk_ready_needs_count:
    assert property ($rose(ready) |-> $past(cnt_q) == '0 && $past(ref_ok_s))
    else $error("ready rose before the settle count ran out");

  chk_out_status_read:
    assert property (s_rd_ctrl ##0 out_now |=> hrdata_out[`SLD_CTRL_OUT_BIT])
    else $error("status read does not show supply at or below level");

  chk_wake_on_flag:
    assert property (evt && ie_q && !wr_ctrl && !wr_mask |=> wake_out)
    else $error("wake request missing for a pending event");

  chk_flag_holds:
    assert property (flag_q && !wr_stat |=> flag_q)
    else $error("event flag dropped without a clear");

  chk_ready_holds:
    assert property (ready && ctrl_q.en |=> ready)
    else $error("ready dropped while still enabled");

  chk_sel_kept:
    assert property ($changed(sel_q) |-> $past(wr_sel) || !por_rstn_in)
    else $error("trip level changed without a write");

  // an edge needs the raw level in two successive samples
  chk_cmp_filtered:
    assert property ($rose(cmp_s) |->
      $past(cmp_raw_in, 3) && $past(cmp_raw_in, 4))
    else $error("comparator edge taken before two samples agreed");

  chk_set_beats_clear:
    assert property (evt |=> flag_q)
    else $error("event lost against a clear");

  chk_off_after_disable:
    assert property ($fell(ctrl_q.en) |=> state_q == SLD_OFF && !ready)
    else $error("detector still active after disable");
endmodule // sld_top
`default_nettype wire

/* File: test/sld_ref_model.sv */
// behavioural supply comparator and reference for the detector bench
`timescale 1ns/10ps
`default_nettype none
module sld_ref_model (
  input wire logic sys_clk_in,
  input wire logic power_in,
  input wire logic [3:0] level_sel_in,
  input wire logic [3:0] supply_in,
  output logic cmp_raw_out,
  output logic ref_ok_raw_out
);
  logic [3:0] warm_q;

  // reference warms up after power-on and stays stable while powered
  always_ff @(posedge sys_clk_in) begin
    if (!power_in)
      warm_q <= 4'h0;
    else if (warm_q != 4'hf)
      warm_q <= warm_q + 4'h1;
  end
  assign ref_ok_raw_out = (warm_q > 4'h3);

  // unpowered comparator gives no valid answer, so it rests low
  assign cmp_raw_out = power_in & (supply_in <= level_sel_in);
endmodule // sld_ref_model
`default_nettype wire

/* File: test/tb_supply_level_detect_control.sv */
// self-checking bench for the supply level detector control
`include "sld_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_supply_level_detect_control;
  localparam logic [11:0] a_ctl = `SLD_CTRL_OFS;
  localparam logic [11:0] a_sel = `SLD_SEL_OFS;
  localparam logic [11:0] a_sta = `SLD_STAT_OFS;
  localparam logic [11:0] a_msk = `SLD_MASK_OFS;
  logic clk, rstn, por_rstn, hwrite, hrdy, irq, wake, pwr, cmp, ref_ok;
  logic hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd_q;
  logic [3:0] sel, supply;
  int mismatches, checks_done;

  sld_top #(.SETTLE_CYC(8)) DUT (.sys_clk_in(clk), .rstn_in(rstn),
    .por_rstn_in(por_rstn), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp), .cmp_raw_in(cmp),
    .ref_ok_raw_in(ref_ok), .level_sel_out(sel),
    .detector_power_out(pwr), .irq_out(irq), .wake_out(wake));
  sld_ref_model partner (.sys_clk_in(clk), .power_in(pwr),
    .level_sel_in(sel), .supply_in(supply), .cmp_raw_out(cmp),
    .ref_ok_raw_out(ref_ok));

  // free running clock; read data caught at the data phase edge
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) rd_q <= hrdata;

  task automatic stop_test();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one single word transfer, held until hready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    #1 rd = rd_q;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask
  // move the supply, then allow the synchroniser time to follow
  task automatic go(input logic [3:0] v);
    @(posedge clk);
    supply <= v;
    idle(12);
  endtask
  task automatic wait_rdy();
    logic [31:0] x;
    x = 32'h0;
    for (int i = 0; i < 40 && x[4] !== 1'b1; i++)
      xfer(1'b0, a_ctl, 32'h0, x);
    chk({31'h0, x[4]}, 32'h1);
  endtask
  // settings change only while the detector is off
  task automatic mode(input logic [7:0] c, input logic [3:0] s);
    wr(a_ctl, 32'h0);
    go(s);
    wr(a_ctl, {24'h0, c});
    wait_rdy();
    rdc(a_sta, 32'h0);
    wr(a_sta, 32'h1);
  endtask

  task automatic t_reset();
    rdc(a_ctl, 32'h0);
    rdc(a_sel, 32'h0);
    rdc(a_sta, 32'h0);
    chk({28'h0, pwr, irq, wake, hresp}, 32'h0);
    wr(12'h010, 32'hffffffff);
    rdc(12'h010, 32'h0);
  endtask
  task automatic t_levels();
    for (int v = 0; v < `SLD_LEVELS; v++) begin
      wr(a_sel, v);
      rdc(a_sel, v);
      chk({28'h0, sel}, v);
    end
    wr(a_sel, 32'h7);
  endtask
  // crossing inside the settle span is dropped, no irq before ready
  task automatic t_settle();
    wr(a_msk, 32'h3);
    rdc(a_msk, 32'h3);
    wr(a_ctl, 32'h81);
    @(posedge clk);
    supply <= 4'h5;
    chk({31'h0, irq}, 32'h0);
    wait_rdy();
    rdc(a_sta, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rdc(a_ctl, 32'hb1);
    wr(a_ctl, 32'h1);
    rdc(a_sta, 32'h0);
    chk({31'h0, pwr}, 32'h0);
  endtask
  task automatic t_fall();
    mode(8'h81, 4'h9);
    rdc(a_ctl, 32'h91);
    go(4'h5);
    rdc(a_sta, 32'h1);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, wake}, 32'h1);
    rdc(a_ctl, 32'hb1);
    wr(a_sta, 32'h1);
    rdc(a_sta, 32'h0);
    go(4'h9);
    rdc(a_sta, 32'h0);
  endtask
  task automatic t_rise();
    mode(8'h82, 4'h5);
    go(4'h9);
    rdc(a_sta, 32'h1);
    wr(a_sta, 32'h1);
    go(4'h5);
    rdc(a_sta, 32'h0);
  endtask
  task automatic t_both();
    mode(8'h83, 4'h9);
    go(4'h5);
    rdc(a_sta, 32'h1);
    wr(a_sta, 32'h1);
    go(4'h9);
    rdc(a_sta, 32'h1);
    // pending flag must keep irq quiet until ready again; wake follows the enable at once
    wr(a_ctl, 32'h3);
    rdc(a_sta, 32'h1);
    wr(a_ctl, 32'h83);
    chk({31'h0, irq}, 32'h0);
    wait_rdy();
    chk({31'h0, irq}, 32'h1);
  endtask
  // device reset keeps the level, power-on reset clears it
  task automatic t_resets();
    wr(a_sel, 32'ha);
    @(posedge clk);
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    rdc(a_sel, 32'ha);
    rdc(a_ctl, 32'h0);
    rdc(a_sta, 32'h0);
    chk({30'h0, irq, wake}, 32'h0);
    chk({31'h0, pwr}, 32'h0);
    @(posedge clk);
    rstn <= 1'b0;
    por_rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    por_rstn <= 1'b1;
    rdc(a_sel, 32'h0);
  endtask

  initial begin
    rstn = 1'b0;
    por_rstn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    supply = 4'h9;
    mismatches = 0;
    checks_done = 0;
    idle(20);
    rstn <= 1'b1;
    por_rstn <= 1'b1;
    t_reset();
    t_levels();
    t_settle();
    t_fall();
    t_rise();
    t_both();
    t_resets();
    stop_test();
  end
  // watchdog far beyond the few hundred cycles the run needs
  initial begin
    idle(20000);
    mismatches++;
    stop_test();
  end
endmodule // tb_supply_level_detect_control
`default_nettype wire
